// ### hw/arcs_pkg.sv
// Constants, register map and carrier types of the audio routing and
// clock select block. Assumes a 32-bit classic Wishbone register bus.
package arcs_pkg;

  localparam int SAMPLE_W = 24;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_CLKSEL = 6'h08;
  localparam logic [5:0] IDX_PRX_CLK = 6'h09;
  localparam logic [5:0] IDX_PTX_CLK = 6'h0A;
  localparam logic [5:0] IDX_SEC_CLK = 6'h0B;
  localparam logic [5:0] IDX_DAC1_SRC = 6'h0C;
  localparam logic [5:0] IDX_PTX_SRC = 6'h0D;
  localparam logic [5:0] IDX_STX_SRC = 6'h0E;
  localparam logic [5:0] IDX_DAC_CTRL = 6'h0F;
  localparam logic [5:0] IDX_DAC_MAP = 6'h10;
  localparam logic [5:0] IDX_SPTX_CTRL = 6'h1E;
  localparam logic [5:0] IDX_STATUS = 6'h20;

  // Field positions
  localparam int SRC_LSB = 7;
  localparam int SPTX_SRC_LSB = 0;
  localparam int BYPASS_BIT = 3;
  localparam int DAC_CLK_LSB = 0;
  localparam int ADC_CLK_LSB = 2;
  localparam int TX_CLK_LSB = 4;
  localparam int MS_CLK_LSB = 6;
  localparam int MASTER_BIT = 0;
  localparam int MODE_BIT = 8;

  // Values after reset
  localparam logic [8:0] RST_DAC1_SRC = 9'h180;
  localparam logic [8:0] RST_PTX_SRC = 9'h080;
  localparam logic [8:0] RST_STX_SRC = 9'h000;
  localparam logic [8:0] RST_SPTX_CTRL = 9'h000;
  localparam logic [8:0] RST_CLKSEL = 9'h000;
  localparam logic [8:0] RST_MS_CLK = 9'h000;
  localparam logic [8:0] RST_DAC_CTRL = 9'h000;
  localparam logic [8:0] RST_DAC_MAP = 9'h0E4;

  // Source codes of the two-bit source fields
  localparam logic [1:0] SRC_SPDIF = 2'h0;
  localparam logic [1:0] SRC_ADC = 2'h1;
  localparam logic [1:0] SRC_SEC = 2'h2;
  localparam logic [1:0] SRC_PRI = 2'h3;

  // Frame clock feeding the DAC rate generator
  localparam logic [1:0] RATE_SPDIF_FRAME = 2'h0;
  localparam logic [1:0] RATE_PRI_LR = 2'h1;
  localparam logic [1:0] RATE_SEC_LR = 2'h2;

  typedef enum logic [1:0] {
    CLK_MCLK = 2'h0,
    CLK_ADCM = 2'h1,
    CLK_PLLA = 2'h2,
    CLK_PLLB = 2'h3
  } arcs_clk_t;

  typedef struct packed {
    logic valid;
    logic [SAMPLE_W-1:0] data;
  } arcs_sample_t;

  typedef struct packed {
    arcs_clk_t dac;
    arcs_clk_t adc;
    arcs_clk_t tx;
    arcs_clk_t prx;
    arcs_clk_t ptx;
    arcs_clk_t sec;
  } arcs_clksel_t;

  typedef struct packed {
    logic [8:0] dac1_src;
    logic [8:0] ptx_src;
    logic [8:0] stx_src;
    logic [8:0] sptx_ctrl;
    logic [8:0] clksel;
    logic [8:0] prx_clk;
    logic [8:0] ptx_clk;
    logic [8:0] sec_clk;
    logic [8:0] dac_ctrl;
    logic [8:0] dac_map;
    logic ack;
    logic [31:0] rdata;
    logic [1:0] pin_sync;
    logic spdif_out;
    arcs_sample_t [3:0] dac;
    logic [3:0] dac_pd;
    logic [1:0] rate_src;
    arcs_sample_t ptx;
    arcs_sample_t stx;
    arcs_sample_t sp_out;
    arcs_sample_t sp_skid;
    logic src_rdy;
    arcs_clksel_t clk;
    logic [2:0] master;
  } arcs_state_t;

endpackage : arcs_pkg

// ### hw/arcs_route.sv
// Audio routing matrix and per-block clock select, with its registers.
// Assumes sample sources run on clk_i; the S/PDIF input pin is asynchronous.
//
// The Wishbone register port was decided locally.
`timescale 1ns/1ns
module arcs_route (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  input wire arcs_pkg::arcs_sample_t [3:0] dac_serial_inputs_i,
  input wire arcs_pkg::arcs_sample_t spdif_rx_i,
  input wire arcs_pkg::arcs_sample_t secondary_rx_i,
  input wire arcs_pkg::arcs_sample_t adc_i,
  input wire logic spdif_in_mux_pin_i,
  input wire logic spdif_tx_line_i,
  input wire logic spdif_tx_ready_i,
  output logic spdif_output_pin_o,
  output arcs_pkg::arcs_sample_t [3:0] dac_o,
  output logic [3:0] dac_pd_o,
  output logic [1:0] dac_rate_src_o,
  output arcs_pkg::arcs_sample_t primary_tx_o,
  output arcs_pkg::arcs_sample_t secondary_tx_o,
  output arcs_pkg::arcs_sample_t spdif_tx_o,
  output logic spdif_tx_src_ready_o,
  output arcs_pkg::arcs_clksel_t clk_sel_o,
  output logic primary_rx_master_o,
  output logic primary_tx_master_o,
  output logic secondary_master_o
);

  arcs_pkg::arcs_state_t q;
  arcs_pkg::arcs_state_t d;
  arcs_pkg::arcs_sample_t [3:0] pri_rx;
  arcs_pkg::arcs_sample_t sptx_in;
  logic [1:0] dac1_sel;
  logic [1:0] ptx_sel;
  logic [1:0] stx_sel;
  logic [1:0] sptx_sel;
  logic spdif_used;
  logic dac_mode;
  logic [5:0] idx;

  function automatic logic [8:0] wr9(input logic [8:0] old,
                                     input logic [31:0] dat,
                                     input logic [3:0] sel);
    logic [8:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      r[8] = dat[8];
    end
    return r;
  endfunction : wr9

  function automatic arcs_pkg::arcs_clk_t pll_pick(input logic [1:0] user);
    arcs_pkg::arcs_clk_t c;
    case (user)
      2'h1: c = arcs_pkg::CLK_PLLA;
      2'h2: c = arcs_pkg::CLK_PLLB;
      default: c = arcs_pkg::CLK_MCLK;
    endcase
    return c;
  endfunction : pll_pick

  // Master-mode sources; PLLs are withheld while the receiver is in use
  function automatic arcs_pkg::arcs_clk_t ms_pick(input logic [1:0] user,
                                                  input logic no_pll);
    arcs_pkg::arcs_clk_t c;
    case (user)
      2'h1: c = no_pll ? arcs_pkg::CLK_MCLK : arcs_pkg::CLK_PLLA;
      2'h2: c = no_pll ? arcs_pkg::CLK_MCLK : arcs_pkg::CLK_PLLB;
      2'h3: c = arcs_pkg::CLK_ADCM;
      default: c = arcs_pkg::CLK_MCLK;
    endcase
    return c;
  endfunction : ms_pick

  function automatic logic [31:0] rd_word(input logic [5:0] i,
                                          input arcs_pkg::arcs_state_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (i)
      arcs_pkg::IDX_CLKSEL: w[8:0] = s.clksel;
      arcs_pkg::IDX_PRX_CLK: w[8:0] = s.prx_clk;
      arcs_pkg::IDX_PTX_CLK: w[8:0] = s.ptx_clk;
      arcs_pkg::IDX_SEC_CLK: w[8:0] = s.sec_clk;
      arcs_pkg::IDX_DAC1_SRC: w[8:0] = s.dac1_src;
      arcs_pkg::IDX_PTX_SRC: w[8:0] = s.ptx_src;
      arcs_pkg::IDX_STX_SRC: w[8:0] = s.stx_src;
      arcs_pkg::IDX_DAC_CTRL: w[8:0] = s.dac_ctrl;
      arcs_pkg::IDX_DAC_MAP: w[8:0] = s.dac_map;
      arcs_pkg::IDX_SPTX_CTRL: w[8:0] = s.sptx_ctrl;
      arcs_pkg::IDX_STATUS: begin
        w = {13'h0, s.sp_skid.valid, s.rate_src, s.dac_pd, s.clk};
      end
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction : rd_word

  assign idx = wb_adr_i[7:2];
  assign dac1_sel = q.dac1_src[arcs_pkg::SRC_LSB +: 2];
  assign ptx_sel = q.ptx_src[arcs_pkg::SRC_LSB +: 2];
  assign stx_sel = q.stx_src[arcs_pkg::SRC_LSB +: 2];
  assign sptx_sel = q.sptx_ctrl[arcs_pkg::SPTX_SRC_LSB +: 2];
  assign dac_mode = q.dac_ctrl[arcs_pkg::MODE_BIT];
  assign spdif_used = (dac1_sel == arcs_pkg::SRC_SPDIF)
                    || (ptx_sel == arcs_pkg::SRC_SPDIF)
                    || (stx_sel == arcs_pkg::SRC_SPDIF)
                    || (sptx_sel == arcs_pkg::SRC_SPDIF);

  // Crossbar of the primary receiver, one mux per DAC
  for (genvar k = 0; k < 4; k++) begin : g_pri
    assign pri_rx[k] = dac_serial_inputs_i[q.dac_map[2*k +: 2]];
  end

  always_comb begin
    d = q;
    // Bus: answer one cycle after the request, drop ack the cycle after
    d.ack = 1'b0;
    if (wb_cyc_i && wb_stb_i && !q.ack) begin
      d.ack = 1'b1;
      d.rdata = rd_word(idx, q);
    end
    // Writes land on the same edge that the master samples ack
    if (wb_cyc_i && wb_stb_i && wb_we_i && q.ack) begin
      case (idx)
        arcs_pkg::IDX_CLKSEL: d.clksel = wr9(q.clksel, wb_dat_i, wb_sel_i);
        arcs_pkg::IDX_PRX_CLK: d.prx_clk = wr9(q.prx_clk, wb_dat_i, wb_sel_i);
        arcs_pkg::IDX_PTX_CLK: d.ptx_clk = wr9(q.ptx_clk, wb_dat_i, wb_sel_i);
        arcs_pkg::IDX_SEC_CLK: d.sec_clk = wr9(q.sec_clk, wb_dat_i, wb_sel_i);
        arcs_pkg::IDX_DAC1_SRC: begin
          d.dac1_src = wr9(q.dac1_src, wb_dat_i, wb_sel_i);
        end
        arcs_pkg::IDX_PTX_SRC: d.ptx_src = wr9(q.ptx_src, wb_dat_i, wb_sel_i);
        arcs_pkg::IDX_STX_SRC: d.stx_src = wr9(q.stx_src, wb_dat_i, wb_sel_i);
        arcs_pkg::IDX_DAC_CTRL: begin
          d.dac_ctrl = wr9(q.dac_ctrl, wb_dat_i, wb_sel_i);
        end
        arcs_pkg::IDX_DAC_MAP: d.dac_map = wr9(q.dac_map, wb_dat_i, wb_sel_i);
        arcs_pkg::IDX_SPTX_CTRL: begin
          d.sptx_ctrl = wr9(q.sptx_ctrl, wb_dat_i, wb_sel_i);
        end
        default: d.ack = 1'b0;
      endcase
    end

    // Output pin: thru path is only resynchronised, not re-encoded
    d.pin_sync = {q.pin_sync[0], spdif_in_mux_pin_i};
    d.spdif_out = q.sptx_ctrl[arcs_pkg::BYPASS_BIT] ? q.pin_sync[1]
                                                    : spdif_tx_line_i;

    // DAC1 source
    case (dac1_sel)
      arcs_pkg::SRC_SPDIF: d.dac[0] = spdif_rx_i;
      arcs_pkg::SRC_SEC: d.dac[0] = secondary_rx_i;
      arcs_pkg::SRC_PRI: d.dac[0] = pri_rx[0];
      default: d.dac[0] = '0;
    endcase
    d.dac_pd = 4'h0;
    for (int k = 1; k < 4; k++) begin
      if (dac1_sel == arcs_pkg::SRC_SPDIF && !dac_mode) begin
        d.dac[k] = '0;
        d.dac_pd[k] = 1'b1;
      end else begin
        d.dac[k] = pri_rx[k];
      end
    end
    case (dac1_sel)
      arcs_pkg::SRC_SPDIF: begin
        d.rate_src = dac_mode ? arcs_pkg::RATE_PRI_LR
                              : arcs_pkg::RATE_SPDIF_FRAME;
      end
      arcs_pkg::SRC_SEC: d.rate_src = arcs_pkg::RATE_SEC_LR;
      default: d.rate_src = arcs_pkg::RATE_PRI_LR;
    endcase

    case (ptx_sel)
      arcs_pkg::SRC_SPDIF: d.ptx = spdif_rx_i;
      arcs_pkg::SRC_ADC: d.ptx = adc_i;
      arcs_pkg::SRC_SEC: d.ptx = secondary_rx_i;
      default: d.ptx = '0;
    endcase
    case (stx_sel)
      arcs_pkg::SRC_SPDIF: d.stx = spdif_rx_i;
      arcs_pkg::SRC_ADC: d.stx = adc_i;
      arcs_pkg::SRC_PRI: d.stx = pri_rx[0];
      default: d.stx = '0;
    endcase

    // Two-entry skid buffer toward the S/PDIF transmitter
    if (q.sp_skid.valid) begin
      sptx_in = '0;
    end else begin
      case (sptx_sel)
        arcs_pkg::SRC_SPDIF: sptx_in = spdif_rx_i;
        arcs_pkg::SRC_ADC: sptx_in = adc_i;
        arcs_pkg::SRC_SEC: sptx_in = secondary_rx_i;
        default: sptx_in = pri_rx[0];
      endcase
    end
    if (spdif_tx_ready_i || !q.sp_out.valid) begin
      if (q.sp_skid.valid) begin
        d.sp_out = q.sp_skid;
        d.sp_skid.valid = 1'b0;
      end else begin
        d.sp_out = sptx_in;
      end
    end else if (sptx_in.valid) begin
      d.sp_skid = sptx_in;
    end
    d.src_rdy = !d.sp_skid.valid;

    // Effective clock selects, user field filtered by the routing
    if (dac1_sel == arcs_pkg::SRC_SPDIF) begin
      d.clk.dac = arcs_pkg::CLK_PLLA;
    end else begin
      d.clk.dac = pll_pick(q.clksel[arcs_pkg::DAC_CLK_LSB +: 2]);
    end
    case (q.clksel[arcs_pkg::ADC_CLK_LSB +: 2])
      2'h1: d.clk.adc = spdif_used ? arcs_pkg::CLK_ADCM : arcs_pkg::CLK_PLLA;
      2'h2: d.clk.adc = spdif_used ? arcs_pkg::CLK_ADCM : arcs_pkg::CLK_PLLB;
      2'h3: d.clk.adc = arcs_pkg::CLK_MCLK;
      default: d.clk.adc = arcs_pkg::CLK_ADCM;
    endcase
    if (sptx_sel == arcs_pkg::SRC_SPDIF) begin
      d.clk.tx = arcs_pkg::CLK_PLLA;
    end else begin
      d.clk.tx = pll_pick(q.clksel[arcs_pkg::TX_CLK_LSB +: 2]);
    end
    d.clk.prx = ms_pick(q.prx_clk[arcs_pkg::MS_CLK_LSB +: 2], spdif_used);
    d.clk.ptx = ms_pick(q.ptx_clk[arcs_pkg::MS_CLK_LSB +: 2], spdif_used);
    d.clk.sec = ms_pick(q.sec_clk[arcs_pkg::MS_CLK_LSB +: 2], spdif_used);
    d.master = {q.sec_clk[arcs_pkg::MASTER_BIT],
                q.ptx_clk[arcs_pkg::MASTER_BIT],
                q.prx_clk[arcs_pkg::MASTER_BIT]};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.dac1_src <= arcs_pkg::RST_DAC1_SRC;
      q.ptx_src <= arcs_pkg::RST_PTX_SRC;
      q.stx_src <= arcs_pkg::RST_STX_SRC;
      q.sptx_ctrl <= arcs_pkg::RST_SPTX_CTRL;
      q.clksel <= arcs_pkg::RST_CLKSEL;
      q.prx_clk <= arcs_pkg::RST_MS_CLK;
      q.ptx_clk <= arcs_pkg::RST_MS_CLK;
      q.sec_clk <= arcs_pkg::RST_MS_CLK;
      q.dac_ctrl <= arcs_pkg::RST_DAC_CTRL;
      q.dac_map <= arcs_pkg::RST_DAC_MAP;
    end else if (ce_i) begin
      q <= d;
    end
  end

  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.rdata;
  assign spdif_output_pin_o = q.spdif_out;
  assign dac_o = q.dac;
  assign dac_pd_o = q.dac_pd;
  assign dac_rate_src_o = q.rate_src;
  assign primary_tx_o = q.ptx;
  assign secondary_tx_o = q.stx;
  assign spdif_tx_o = q.sp_out;
  // Registered ready: the source stalls once the spare slot is taken
  assign spdif_tx_src_ready_o = q.src_rdy;
  assign clk_sel_o = q.clk;
  assign primary_rx_master_o = q.master[0];
  assign primary_tx_master_o = q.master[1];
  assign secondary_master_o = q.master[2];

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  dac1_primary_a: assert property (
    ce_i && dac1_sel == arcs_pkg::SRC_PRI |=> q.dac[0] == $past(pri_rx[0]))
    else $error("DAC1 does not carry primary receive data");
  dac1_spdif_a: assert property (
    ce_i && dac1_sel == arcs_pkg::SRC_SPDIF |=> q.dac[0] == $past(spdif_rx_i))
    else $error("DAC1 does not carry S/PDIF receive data");
  dac_powerdown_a: assert property (
    ce_i && dac1_sel == arcs_pkg::SRC_SPDIF && !dac_mode
    |=> q.dac_pd == 4'hE && !q.dac[3].valid)
    else $error("DACs two to four not powered down");
  dac_mode_route_a: assert property (
    ce_i && dac1_sel == arcs_pkg::SRC_SPDIF && dac_mode
    |=> q.dac[2] == $past(pri_rx[2]) && q.rate_src == arcs_pkg::RATE_PRI_LR)
    else $error("Mode set but DAC3 not fed from primary receiver");
  ptx_adc_a: assert property (
    ce_i && ptx_sel == arcs_pkg::SRC_ADC |=> q.ptx == $past(adc_i))
    else $error("Primary transmit does not carry ADC data");
  ptx_undefined_a: assert property (
    ce_i && ptx_sel == 2'h3 |=> q.ptx == '0)
    else $error("Undefined primary transmit source not zero");
  stx_primary_a: assert property (
    ce_i && stx_sel == arcs_pkg::SRC_PRI |=> q.stx == $past(pri_rx[0]))
    else $error("Secondary transmit not fed from DAC1 serial input");
  bypass_pin_a: assert property (
    ce_i && q.sptx_ctrl[arcs_pkg::BYPASS_BIT]
    |=> spdif_output_pin_o == $past(q.pin_sync[1]))
    else $error("Bypass set but pin not driven from input mux");
  dac_clk_auto_a: assert property (
    ce_i && dac1_sel == arcs_pkg::SRC_SPDIF
    |=> clk_sel_o.dac == arcs_pkg::CLK_PLLA)
    else $error("DAC clock not forced while S/PDIF feeds DAC1");
  adc_clk_pll_a: assert property (
    ce_i && spdif_used |=> clk_sel_o.adc != arcs_pkg::CLK_PLLA
                        && clk_sel_o.adc != arcs_pkg::CLK_PLLB)
    else $error("ADC clock on a PLL while receiver in use");
  sptx_hold_a: assert property (
    q.sp_out.valid && !spdif_tx_ready_i |=> $stable(q.sp_out))
    else $error("S/PDIF transmit word changed while stalled");
  stx_adc_a: assert property (
    ce_i && stx_sel == arcs_pkg::SRC_ADC |=> q.stx == $past(adc_i))
    else $error("Secondary transmit does not carry ADC data");
  stx_spdif_a: assert property (
    ce_i && stx_sel == arcs_pkg::SRC_SPDIF |=> q.stx == $past(spdif_rx_i))
    else $error("Secondary transmit does not carry S/PDIF data");
  ptx_secondary_a: assert property (
    ce_i && ptx_sel == arcs_pkg::SRC_SEC |=> q.ptx == $past(secondary_rx_i))
    else $error("Primary transmit does not carry secondary data");
  dac1_undefined_a: assert property (
    ce_i && dac1_sel == arcs_pkg::SRC_ADC |=> q.dac[0] == '0)
    else $error("Undefined DAC1 source not zero");
  dac_map_route_a: assert property (
    ce_i && dac1_sel != arcs_pkg::SRC_SPDIF
    |=> q.dac[1] == $past(dac_serial_inputs_i[q.dac_map[3:2]]))
    else $error("DAC2 not fed from its mapped serial input");
  dac_pd_off_a: assert property (
    ce_i && dac1_sel != arcs_pkg::SRC_SPDIF |=> q.dac_pd == 4'h0)
    else $error("DAC powered down while DAC1 not on S/PDIF");
  tx_clk_auto_a: assert property (
    ce_i && sptx_sel == arcs_pkg::SRC_SPDIF
    |=> clk_sel_o.tx == arcs_pkg::CLK_PLLA)
    else $error("Transmit clock not forced while thru source chosen");
  dac_clk_user_a: assert property (
    ce_i && dac1_sel != arcs_pkg::SRC_SPDIF
    && q.clksel[arcs_pkg::DAC_CLK_LSB +: 2] == 2'h2
    |=> clk_sel_o.dac == arcs_pkg::CLK_PLLB)
    else $error("DAC clock does not follow the user field");
  adc_clk_user_a: assert property (
    ce_i && !spdif_used && q.clksel[arcs_pkg::ADC_CLK_LSB +: 2] == 2'h1
    |=> clk_sel_o.adc == arcs_pkg::CLK_PLLA)
    else $error("ADC clock does not follow the user field");
  clk_subset_a: assert property (
    clk_sel_o.dac != arcs_pkg::CLK_ADCM && clk_sel_o.tx != arcs_pkg::CLK_ADCM)
    else $error("DAC or transmit clock taken from the ADC clock pin");
  prx_clk_pll_a: assert property (
    ce_i && spdif_used |=> clk_sel_o.prx != arcs_pkg::CLK_PLLA
                        && clk_sel_o.prx != arcs_pkg::CLK_PLLB)
    else $error("Primary receive clock on a PLL while receiver in use");
  master_mode_a: assert property (
    ce_i |=> primary_rx_master_o == $past(q.prx_clk[arcs_pkg::MASTER_BIT])
          && primary_tx_master_o == $past(q.ptx_clk[arcs_pkg::MASTER_BIT])
          && secondary_master_o == $past(q.sec_clk[arcs_pkg::MASTER_BIT]))
    else $error("Master mode output does not follow its register");

  spdif_mode_c: cover property (
    dac1_sel == arcs_pkg::SRC_SPDIF && dac_mode ##1 q.dac[1].valid);
  skid_full_c: cover property (
    q.sp_skid.valid && !spdif_tx_ready_i ##1 spdif_tx_ready_i);
  bypass_c: cover property (
    q.sptx_ctrl[arcs_pkg::BYPASS_BIT] ##2 spdif_output_pin_o);
  bus_write_c: cover property (
    wb_cyc_i && wb_stb_i && wb_we_i && q.ack);
  enable_low_c: cover property (
    !ce_i ##1 ce_i);

endmodule : arcs_route

// ### verif/arcs_tx_sink.sv
// Model of the S/PDIF transmitter that takes words from the routing block.
// Assumes the shared clock; it stalls only while the bench asks it to.
`timescale 1ns/1ns
module arcs_tx_sink (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic stall_i,
  output logic ready_o,
  output logic line_o
);
  logic [15:0] lfsr;
  // Pseudo-random line so that a stale or stuck pin is caught
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lfsr <= 16'hACE1;
    end else begin
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    end
  end
  assign line_o = lfsr[0];
  // Stalls about three cycles in four, enough to fill both entries
  assign ready_o = stall_i ? (lfsr[3] & lfsr[7]) : 1'b1;
endmodule : arcs_tx_sink

// ### verif/tb.sv
// Self-checking bench for the routing and clock select block.
// Assumes the design package is compiled first and one 100 MHz clock.
`timescale 1ns/1ns
module tb;
  logic clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [3:0] wb_sel_i, dac_pd_o;
  arcs_pkg::arcs_sample_t [3:0] din, dac_o;
  arcs_pkg::arcs_sample_t sprx, secrx, adc, ptx_o, stx_o, sptx_o, old;
  logic in_pin, tx_line, tx_ready, src_ready, stall, mon, pin_o, t;
  logic [1:0] rate_o, uu;
  logic [2:0] ms_o, h;
  arcs_pkg::arcs_clksel_t clk_o;
  int miscompares = 0;
  int cmp_count = 0;
  int map = 'hE4;
  int refused = 0;
  arcs_pkg::arcs_sample_t q[$];

  arcs_route dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .dac_serial_inputs_i(din),
    .spdif_rx_i(sprx), .secondary_rx_i(secrx), .adc_i(adc),
    .spdif_in_mux_pin_i(in_pin), .spdif_tx_line_i(tx_line),
    .spdif_tx_ready_i(tx_ready), .spdif_output_pin_o(pin_o),
    .dac_o(dac_o), .dac_pd_o(dac_pd_o), .dac_rate_src_o(rate_o),
    .primary_tx_o(ptx_o), .secondary_tx_o(stx_o), .spdif_tx_o(sptx_o),
    .spdif_tx_src_ready_o(src_ready), .clk_sel_o(clk_o),
    .primary_rx_master_o(ms_o[0]), .primary_tx_master_o(ms_o[1]),
    .secondary_master_o(ms_o[2]));
  arcs_tx_sink sink (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall),
    .ready_o(tx_ready), .line_o(tx_line));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report

  // One classic cycle; the slave decides when to answer
  task automatic wb(input logic we, input logic [7:0] a, input int d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= 32'(d);
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    check(32'(n < 20), 32'h1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task automatic rnd_src();
    for (int k = 0; k < 4; k++) din[k] <= {1'b1, 24'($urandom)};
    sprx <= {1'b1, 24'($urandom)};
    secrx <= {1'b1, 24'($urandom)};
    adc <= {1'b1, 24'($urandom)};
  endtask : rnd_src

  // Reference source for a two-bit code; code 3 is DAC1's serial input
  function automatic arcs_pkg::arcs_sample_t pick(int c, int undef);
    arcs_pkg::arcs_sample_t s[4];
    s[0] = sprx;
    s[1] = adc;
    s[2] = secrx;
    s[3] = din[map & 3];
    return (c == undef) ? '0 : s[c];
  endfunction : pick

  // kind 0 DAC or tx, 1 ADC, 2 master select; sp: S/PDIF receive in use
  function automatic int ck(int u, int kind, int sp);
    if (kind == 0) return (u == 1) ? 2 : (u == 2) ? 3 : 0;
    if (u == 0) return (kind == 1) ? 1 : 0;
    if (u == 3) return (kind == 1) ? 0 : 1;
    return sp ? ((kind == 1) ? 1 : 0) : u + 1;
  endfunction : ck

  // Reference buffer: words taken while ready must leave in order
  always @(posedge clk_i) begin
    if (mon) begin
      if (sptx_o.valid && tx_ready) begin
        check(32'(q.size() > 0), 32'h1);
        if (q.size() > 0) check(sptx_o, q.pop_front());
      end
      if (adc.valid && src_ready) q.push_back(adc);
      if (adc.valid && !src_ready) refused++;
    end
  end

  initial begin
    #400000;
    miscompares++;
    $display("mismatch at %0t: watchdog expired", $time);
    final_report();
  end

  initial begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'hF;
    din = '0;
    sprx = '0;
    secrx = '0;
    adc = '0;
    in_pin = 1'b0;
    stall = 1'b0;
    mon = 1'b0;
    void'($urandom(40738));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h30, 0);
    check(rd, 32'h180);
    wb(1'b0, 8'h34, 0);
    check(rd, 32'h080);
    wb(1'b0, 8'h38, 0);
    check(rd, 32'h000);
    wb(1'b0, 8'h78, 0);
    check(rd, 32'h000);
    wb(1'b1, 8'hFC, -1);
    wb(1'b0, 8'hFC, 0);
    check(rd, 32'h0);
    wb(1'b1, 8'h78, -1);
    wb(1'b0, 8'h78, 0);
    check(rd, 32'h1FF);
    $display("test registers done");
    for (int p = 0; p < 3; p++) begin
      map = (p == 0) ? 'hE4 : (p == 1) ? 'h1B : int'($urandom & 'hFF);
      wb(1'b1, 8'h40, map);
      for (int m = 0; m < 2; m++) begin
        wb(1'b1, 8'h3C, m << 8);
        for (int c = 0; c < 4; c++) begin
          rnd_src();
          wb(1'b1, 8'h30, c << 7);
          wb(1'b1, 8'h34, c << 7);
          wb(1'b1, 8'h38, c << 7);
          wb(1'b1, 8'h78, c);
          repeat (3) @(posedge clk_i);
          check(dac_o[0], pick(c, 1));
          check(ptx_o, pick(c, 3));
          check(stx_o, pick(c, 2));
          check(sptx_o, pick(c, 4));
          check(dac_pd_o, (c == 0 && m == 0) ? 4'hE : 4'h0);
          if (c != 1) check(rate_o, c == 0 ? m : c == 2 ? 2 : 1);
          for (int k = 1; k < 4; k++) begin
            rd = (c == 0 && m == 0) ? 32'h0 : {7'h00, din[(map >> 2 * k) & 3]};
            check(dac_o[k], rd);
          end
        end
      end
    end
    $display("test routing done");
    for (int sp = 0; sp < 2; sp++) begin
      wb(1'b1, 8'h30, sp ? 0 : 'h180);
      wb(1'b1, 8'h34, 'h080);
      wb(1'b1, 8'h38, 'h080);
      wb(1'b1, 8'h78, sp ? 0 : 1);
      for (int u = 0; u < 4; u++) begin
        uu = 2'(u);
        wb(1'b1, 8'h20, u * 'h15);
        wb(1'b1, 8'h24, (u << 6) | uu[0]);
        wb(1'b1, 8'h28, (u << 6) | uu[1]);
        wb(1'b1, 8'h2C, (u << 6) | !uu[0]);
        repeat (3) @(posedge clk_i);
        check(clk_o.dac, sp ? 2 : ck(u, 0, 0));
        check(clk_o.tx, sp ? 2 : ck(u, 0, 0));
        check(clk_o.adc, ck(u, 1, sp));
        check(clk_o.prx, ck(u, 2, sp));
        check(clk_o.ptx, ck(u, 2, sp));
        check(clk_o.sec, ck(u, 2, sp));
        check(ms_o, {!uu[0], uu[1], uu[0]});
      end
    end
    $display("test clocks done");
    wb(1'b1, 8'h78, 1);
    adc <= '0;
    repeat (6) @(posedge clk_i);
    stall <= 1'b1;
    mon <= 1'b1;
    repeat (200) begin
      @(posedge clk_i);
      adc <= {1'($urandom), 24'($urandom)};
    end
    adc <= '0;
    stall <= 1'b0;
    repeat (10) @(posedge clk_i);
    mon <= 1'b0;
    check(q.size(), 0);
    check(32'(refused > 0), 32'h1);
    $display("test buffer done");
    // Pin path: bypass clear follows the line, set follows the input mux
    for (int b = 0; b < 2; b++) begin
      wb(1'b1, 8'h78, 1 | (b << 3));
      for (int i = 0; i < 30; i++) begin
        @(posedge clk_i);
        if (i > 4) check(pin_o, b ? h[2] : t);
        h = {h[1:0], in_pin};
        t = tx_line;
        in_pin <= 1'($urandom);
      end
    end
    $display("test bypass done");
    // Enable low must freeze the routed samples while the sources move
    old = sprx;
    ce_i <= 1'b0;
    rnd_src();
    repeat (3) @(posedge clk_i);
    check(dac_o[0], old);
    check(dac_pd_o, 4'h0);
    ce_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    check(dac_o[0], sprx);
    check(dac_o[2], din[(map >> 4) & 3]);
    $display("test enable done");
    // Reset in mid-run brings the source fields back to their defaults
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h78, 0);
    check(rd, 32'h000);
    wb(1'b0, 8'h30, 0);
    check(rd, 32'h180);
    wb(1'b0, 8'h40, 0);
    check(rd, 32'h0E4);
    $display("test reset done");
    final_report();
  end
endmodule : tb
